/* hw/ctp_table_port.sv */
`timescale 1ns/1ns
`include "ctp_cfg.svh"
// Overview of operation
// - select bits 1:0 choose offset, gain or gamma table; 11 undefined
// - select bits 3:2 choose red, green or blue plane; 11 undefined
// - 14-bit index: bits 13:8 from register 4, bits 7:0 from register 5
// - register 4 bit 6 announces reads (1) or writes (0) on the window
// - in read direction the word is prefetched from memory ahead of reads
// - index advances by one after every complete two-byte word
// - gamma index range is 0 to 4093
// - gain and offset index range is 0 to 16383
// - index wraps to zero past the last entry and keeps counting
// - 8-bit data window at address 06 streams bytes of the table
// - offset word: bits 13:6 first, then bits 5:0 shifted left two
// - gain word: high byte first, then low byte
// - gamma word: bits 11:8 in low nibble first, then bits 7:0
// - address write first, then any number of data reads or writes
// - select register bit 4 is read-only; writes leave it alone
module ctp_table_port
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // configuration register port
   input wire logic cfg_addr_stb,
   input wire logic cfg_wr_stb,
   input wire logic cfg_rd_stb,
   input wire logic [7:0] cfg_wdata,
   output logic [7:0] cfg_rdata_q,
   output logic cfg_rvalid_q,
   output logic port_busy_q,
   // read-only status shown in select bit 4
   input wire logic select_status_in,
   // external memory word port
   output logic mem_req_q,
   output logic mem_we_q,
   output logic [19:0] mem_addr_q,
   output logic [15:0] mem_wdata_q,
   input wire logic mem_ack,
   input wire logic [15:0] mem_rdata
);
   ctp_pkg::ctp_state_type state_q, state_d;
   logic [6:0] addr_q, addr_d;
   logic [3:0] sel_q, sel_d;
   logic dir_q, dir_d;
   logic phase_q, phase_d;
   logic [7:0] hold_q, hold_d;
   logic [15:0] pf_q, pf_d;
   logic pf_valid_q, pf_valid_d;
   logic rd_pend_q, rd_pend_d;
   logic fetch_go_q, fetch_go_d;
   logic [7:0] cfg_rdata_d;
   logic cfg_rvalid_d;
   logic mem_req_d, mem_we_d;
   logic [19:0] mem_addr_d;
   logic [15:0] mem_wdata_d;
   logic idx_load, idx_step;
   logic [13:0] idx_load_val;
   logic [13:0] idx_q;
   logic [1:0] tbl;
   logic [1:0] col;
   logic undef;
   logic [19:0] word_addr;

   // ==========================================================
   // decode of the selected table and plane
   assign tbl = sel_q[`CTP_TABLE_LSB +: 2];
   assign col = sel_q[`CTP_COLOUR_LSB +: 2];
   assign undef = (tbl == `CTP_CODE_UNDEF) || (col == `CTP_CODE_UNDEF);

   // word address: table base plus plane plus index
   always_comb
   begin
      if (tbl == `CTP_TBL_GAMMA)
      begin
         word_addr = `CTP_BASE_GAMMA + ({18'h00000, col} << `CTP_GAMMA_PLANE_SHIFT) + {6'h00, idx_q};
      end
      else if (tbl == `CTP_TBL_GAIN)
      begin
         word_addr = `CTP_BASE_GAIN + ({18'h00000, col} << `CTP_COEF_PLANE_SHIFT) + {6'h00, idx_q};
      end
      else
      begin
         word_addr = `CTP_BASE_OFFSET + ({18'h00000, col} << `CTP_COEF_PLANE_SHIFT) + {6'h00, idx_q};
      end
   end

   // ==========================================================
   // byte of a stored word as seen through the window
   function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic [1:0] t, input logic ph);
      logic [7:0] b;
      b = 8'h00;
      if (t == `CTP_TBL_OFFSET)
      begin
         b = ph ? {w[5:0], 2'b00} : w[13:6];
      end
      else if (t == `CTP_TBL_GAIN)
      begin
         b = ph ? w[7:0] : w[15:8];
      end
      else
      begin
         b = ph ? w[7:0] : {4'h0, w[11:8]};
      end
      return b;
   endfunction

   // stored word built from the two window bytes
   function automatic logic [15:0] pack_word(input logic [7:0] h, input logic [7:0] l, input logic [1:0] t);
      logic [15:0] w;
      w = {h, l};
      if (t == `CTP_TBL_OFFSET)
      begin
         w = {2'b00, h, l[7:2]};
      end
      else if (t == `CTP_TBL_GAMMA)
      begin
         w = {4'h0, h[3:0], l};
      end
      return w;
   endfunction

   // ==========================================================
   // index counter
   ctp_index_ctr u_index
   (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .load(idx_load),
      .load_val(idx_load_val),
      .step(idx_step),
      .gamma_sel(tbl == `CTP_TBL_GAMMA),
      .idx_q(idx_q)
   );

   // ==========================================================
   // register decode, byte sequencing and memory requests
   always_comb
   begin
      state_d = state_q;
      addr_d = addr_q;
      sel_d = sel_q;
      dir_d = dir_q;
      phase_d = phase_q;
      hold_d = hold_q;
      pf_d = pf_q;
      pf_valid_d = pf_valid_q;
      rd_pend_d = rd_pend_q;
      fetch_go_d = 1'b0;
      cfg_rdata_d = cfg_rdata_q;
      cfg_rvalid_d = 1'b0;
      mem_req_d = mem_req_q;
      mem_we_d = mem_we_q;
      mem_addr_d = mem_addr_q;
      mem_wdata_d = mem_wdata_q;
      idx_load = 1'b0;
      idx_load_val = idx_q;
      idx_step = 1'b0;
      // address phase of a register access
      if (cfg_addr_stb)
      begin
         addr_d = cfg_wdata[6:0];
      end
      // register writes
      else if (cfg_wr_stb)
      begin
         if (addr_q == `CTP_REG_SELECT)
         begin
            sel_d = cfg_wdata[3:0];
            phase_d = 1'b0;
            pf_valid_d = 1'b0;
         end
         else if (addr_q == `CTP_REG_INDEX_HI)
         begin
            idx_load = 1'b1;
            idx_load_val = {cfg_wdata[5:0], idx_q[7:0]};
            dir_d = cfg_wdata[`CTP_DIR_BIT];
            phase_d = 1'b0;
            pf_valid_d = 1'b0;
            fetch_go_d = cfg_wdata[`CTP_DIR_BIT] && !undef;
         end
         else if (addr_q == `CTP_REG_INDEX_LO)
         begin
            idx_load = 1'b1;
            idx_load_val = {idx_q[13:8], cfg_wdata};
            phase_d = 1'b0;
            pf_valid_d = 1'b0;
            fetch_go_d = dir_q && !undef;
         end
         else if (addr_q == `CTP_REG_WINDOW && !dir_q && !undef)
         begin
            if (!phase_q)
            begin
               hold_d = cfg_wdata;
               phase_d = 1'b1;
            end
            else
            begin
               phase_d = 1'b0;
               mem_req_d = 1'b1;
               mem_we_d = 1'b1;
               mem_addr_d = word_addr;
               mem_wdata_d = pack_word(hold_q, cfg_wdata, tbl);
               idx_step = 1'b1;
               state_d = ctp_pkg::CTP_STORE;
            end
         end
      end
      // register reads
      else if (cfg_rd_stb)
      begin
         if (addr_q == `CTP_REG_SELECT)
         begin
            cfg_rdata_d = {3'h0, select_status_in, sel_q};
            cfg_rvalid_d = 1'b1;
         end
         else if (addr_q == `CTP_REG_INDEX_HI)
         begin
            cfg_rdata_d = {1'b0, dir_q, idx_q[13:8]};
            cfg_rvalid_d = 1'b1;
         end
         else if (addr_q == `CTP_REG_INDEX_LO)
         begin
            cfg_rdata_d = idx_q[7:0];
            cfg_rvalid_d = 1'b1;
         end
         else if (addr_q == `CTP_REG_WINDOW)
         begin
            if (undef || !dir_q)
            begin
               cfg_rdata_d = 8'h00;
               cfg_rvalid_d = 1'b1;
            end
            else if (pf_valid_q)
            begin
               cfg_rdata_d = pick_byte(pf_q, tbl, phase_q);
               cfg_rvalid_d = 1'b1;
               phase_d = !phase_q;
               if (phase_q)
               begin
                  idx_step = 1'b1;
                  pf_valid_d = 1'b0;
                  fetch_go_d = 1'b1;
               end
            end
            else
            begin
               rd_pend_d = 1'b1;
               // no fetch in flight: start one so the waiting read cannot hang
               fetch_go_d = (state_q == ctp_pkg::CTP_IDLE) && !fetch_go_q;
            end
         end
      end
      // memory sequencer
      case (state_q)
         ctp_pkg::CTP_IDLE:
         begin
            if (fetch_go_q)
            begin
               mem_req_d = 1'b1;
               mem_we_d = 1'b0;
               mem_addr_d = word_addr;
               state_d = ctp_pkg::CTP_FETCH;
            end
         end
         ctp_pkg::CTP_FETCH:
         begin
            if (mem_ack)
            begin
               mem_req_d = 1'b0;
               state_d = ctp_pkg::CTP_IDLE;
               if (rd_pend_q)
               begin
                  // a read waiting on this fetch is answered straight from it
                  rd_pend_d = 1'b0;
                  cfg_rdata_d = pick_byte(mem_rdata, tbl, phase_q);
                  cfg_rvalid_d = 1'b1;
                  phase_d = !phase_q;
                  pf_d = mem_rdata;
                  pf_valid_d = !phase_q;
                  if (phase_q)
                  begin
                     idx_step = 1'b1;
                     fetch_go_d = 1'b1;
                  end
               end
               else
               begin
                  pf_d = mem_rdata;
                  pf_valid_d = 1'b1;
               end
            end
         end
         ctp_pkg::CTP_STORE:
         begin
            if (mem_ack)
            begin
               mem_req_d = 1'b0;
               mem_we_d = 1'b0;
               state_d = ctp_pkg::CTP_IDLE;
            end
         end
         default:
         begin
            state_d = ctp_pkg::CTP_IDLE;
         end
      endcase
   end

   // ==========================================================
   // state registers
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_q <= ctp_pkg::CTP_IDLE;
         addr_q <= 7'h00;
         sel_q <= `CTP_SEL_RESET;
         dir_q <= `CTP_DIR_RESET;
         phase_q <= 1'b0;
         hold_q <= 8'h00;
         pf_q <= 16'h0000;
         pf_valid_q <= 1'b0;
         rd_pend_q <= 1'b0;
         fetch_go_q <= 1'b0;
         cfg_rdata_q <= 8'h00;
         cfg_rvalid_q <= 1'b0;
         port_busy_q <= 1'b0;
         mem_req_q <= 1'b0;
         mem_we_q <= 1'b0;
         mem_addr_q <= 20'h00000;
         mem_wdata_q <= 16'h0000;
      end
      else
      begin
         state_q <= state_d;
         addr_q <= addr_d;
         sel_q <= sel_d;
         dir_q <= dir_d;
         phase_q <= phase_d;
         hold_q <= hold_d;
         pf_q <= pf_d;
         pf_valid_q <= pf_valid_d;
         rd_pend_q <= rd_pend_d;
         fetch_go_q <= fetch_go_d;
         cfg_rdata_q <= cfg_rdata_d;
         cfg_rvalid_q <= cfg_rvalid_d;
         port_busy_q <= fetch_go_d || rd_pend_d || (state_d != ctp_pkg::CTP_IDLE);
         mem_req_q <= mem_req_d;
         mem_we_q <= mem_we_d;
         mem_addr_q <= mem_addr_d;
         mem_wdata_q <= mem_wdata_d;
      end
   end
endmodule

/* shared/ctp_cfg.svh */
`ifndef CTP_CFG_SVH
`define CTP_CFG_SVH
// ==========================================================
// configuration register offsets
`define CTP_REG_SELECT 7'h03
`define CTP_REG_INDEX_HI 7'h04
`define CTP_REG_INDEX_LO 7'h05
`define CTP_REG_WINDOW 7'h06
// ==========================================================
// field positions
`define CTP_TABLE_LSB 0
`define CTP_COLOUR_LSB 2
`define CTP_RO_BIT 4
`define CTP_DIR_BIT 6
// ==========================================================
// codes, limits and reset values
`define CTP_TBL_OFFSET 2'h0
`define CTP_TBL_GAIN 2'h1
`define CTP_TBL_GAMMA 2'h2
`define CTP_CODE_UNDEF 2'h3
`define CTP_GAMMA_LAST 14'hFFD
`define CTP_COEF_LAST 14'h3FFF
`define CTP_SEL_RESET 4'h0
`define CTP_INDEX_RESET 14'h0000
`define CTP_DIR_RESET 1'h0
// ==========================================================
// external memory word map
`define CTP_BASE_OFFSET 20'h00000
`define CTP_BASE_GAIN 20'h0C000
`define CTP_BASE_GAMMA 20'h18000
`define CTP_COEF_PLANE_SHIFT 14
`define CTP_GAMMA_PLANE_SHIFT 12
`endif

/* shared/ctp_pkg.sv */
package ctp_pkg;
   // ==========================================================
   // sequencer states
   typedef enum logic [1:0]
   {
      CTP_IDLE = 2'b00,
      CTP_FETCH = 2'b01,
      CTP_STORE = 2'b10
   } ctp_state_type;
endpackage

/* hw/ctp_index_ctr.sv */
`timescale 1ns/1ns
`include "ctp_cfg.svh"
module ctp_index_ctr
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // control
   input wire logic load,
   input wire logic [13:0] load_val,
   input wire logic step,
   input wire logic gamma_sel,
   // index
   output logic [13:0] idx_q
);
   logic [13:0] idx_d;
   logic [13:0] last;

   // ==========================================================
   // next index with wrap at the table end
   always_comb
   begin
      last = gamma_sel ? `CTP_GAMMA_LAST : `CTP_COEF_LAST;
      idx_d = idx_q;
      if (load)
      begin
         idx_d = load_val;
      end
      else if (step)
      begin
         if (idx_q >= last)
         begin
            idx_d = 14'h0000;
         end
         else
         begin
            idx_d = idx_q + 14'h0001;
         end
      end
   end

   // index register
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         idx_q <= `CTP_INDEX_RESET;
      end
      else
      begin
         idx_q <= idx_d;
      end
   end
endmodule

/* verif/ctp_mem_model.sv */
`timescale 1ns/1ns
// ==========================================================
// word memory that answers the table port, prompt or slow
module ctp_mem_model
(
   // clock
   input wire logic ref_clk,
   // memory word port
   input wire logic mem_req_q,
   input wire logic mem_we_q,
   input wire logic [19:0] mem_addr_q,
   input wire logic [15:0] mem_wdata_q,
   output logic mem_ack,
   output logic [15:0] mem_rdata,
   // answer after five cycles instead of one
   input wire logic slow
);
   logic [15:0] mem [logic [19:0]];
   int n_wr = 0;
   int wait_n = 0;
   initial
   begin
      mem_ack = 1'b0;
      mem_rdata = 16'h0000;
   end
   // read data garbles every cycle outside the ack so stale words never pass
   always @(posedge ref_clk)
   begin
      if (mem_req_q && !mem_ack && wait_n >= (slow ? 4 : 0))
      begin
         wait_n = 0;
         mem_ack <= 1'b1;
         if (mem_we_q)
         begin
            mem[mem_addr_q] = mem_wdata_q;
            n_wr++;
            mem_rdata <= ~mem_rdata;
         end
         else
         begin
            mem_rdata <= mem.exists(mem_addr_q) ? mem[mem_addr_q] : 16'h0000;
         end
      end
      else
      begin
         if (mem_req_q && !mem_ack)
         begin
            wait_n = wait_n + 1;
         end
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule

/* verif/ctp_table_port_sva.sv */
`timescale 1ns/1ns
`include "ctp_cfg.svh"
// ==========================================================
// port checker for the table port
module ctp_table_port_sva
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // configuration register port
   input wire logic cfg_addr_stb,
   input wire logic cfg_wr_stb,
   input wire logic cfg_rd_stb,
   input wire logic [7:0] cfg_wdata,
   input wire logic [7:0] cfg_rdata_q,
   input wire logic cfg_rvalid_q,
   input wire logic port_busy_q,
   input wire logic select_status_in,
   // memory word port
   input wire logic mem_req_q,
   input wire logic mem_we_q,
   input wire logic [19:0] mem_addr_q,
   input wire logic [15:0] mem_wdata_q,
   input wire logic mem_ack
);
   logic [6:0] addr_q;
   logic [3:0] sel_q;
   logic dir_q;
   logic rd_take;
   assign rd_take = cfg_rd_stb && !cfg_addr_stb && !cfg_wr_stb && !port_busy_q;
   // shadow of the address latch, select and direction
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         addr_q <= 7'h00;
         sel_q <= 4'h0;
         dir_q <= 1'b0;
      end
      else if (cfg_addr_stb)
         addr_q <= cfg_wdata[6:0];
      else if (cfg_wr_stb && addr_q == `CTP_REG_SELECT)
         sel_q <= cfg_wdata[3:0];
      else if (cfg_wr_stb && addr_q == `CTP_REG_INDEX_HI)
         dir_q <= cfg_wdata[`CTP_DIR_BIT];
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   property p_req_hold; mem_req_q && !mem_ack |=> mem_req_q && $stable({mem_we_q, mem_addr_q, mem_wdata_q}); endproperty
   a_req_hold: assert property (p_req_hold)
      else $error("memory request changed before ack");
   property p_req_drop; mem_req_q && mem_ack |=> !mem_req_q; endproperty
   a_req_drop: assert property (p_req_drop)
      else $error("memory request held after ack");
   property p_busy; mem_req_q |-> port_busy_q; endproperty
   a_busy: assert property (p_busy)
      else $error("memory request while port idle");
   property p_answer; rd_take && addr_q inside {[3:5]} |=> cfg_rvalid_q; endproperty
   a_answer: assert property (p_answer)
      else $error("register read not answered next cycle");
   property p_silent; rd_take && !(addr_q inside {[3:6]}) |=> !cfg_rvalid_q; endproperty
   a_silent: assert property (p_silent)
      else $error("answer to a foreign address");
   property p_ro_bit; rd_take && addr_q == 7'h03 |=> cfg_rdata_q == {3'h0, $past(select_status_in), sel_q}; endproperty
   a_ro_bit: assert property (p_ro_bit)
      else $error("select readback wrong");
   property p_dir; $rose(mem_req_q) |-> mem_we_q == !dir_q; endproperty
   a_dir: assert property (p_dir)
      else $error("memory direction against port direction");
   property p_undef; $rose(mem_req_q) |-> sel_q[1:0] != 2'h3 && sel_q[3:2] != 2'h3; endproperty
   a_undef: assert property (p_undef)
      else $error("memory touched with undefined select");
   property p_coef; $rose(mem_req_q) && sel_q[1:0] != `CTP_TBL_GAMMA
      |-> mem_addr_q[19:14] == (sel_q[1:0] == `CTP_TBL_GAIN ? 6'h03 : 6'h00) + {4'h0, sel_q[3:2]}; endproperty
   a_coef: assert property (p_coef)
      else $error("coefficient plane address wrong");
   property p_gamma; $rose(mem_req_q) && sel_q[1:0] == `CTP_TBL_GAMMA
      |-> mem_addr_q[19:12] == 8'h18 + {6'h00, sel_q[3:2]} && mem_addr_q[11:0] <= 12'hFFD; endproperty
   a_gamma: assert property (p_gamma)
      else $error("gamma address outside its plane");
   property p_width; $rose(mem_req_q) && mem_we_q && sel_q[1:0] != `CTP_TBL_GAIN
      |-> mem_wdata_q[15:14] == 2'h0 && (sel_q[1:0] != `CTP_TBL_GAMMA || mem_wdata_q[13:12] == 2'h0); endproperty
   a_width: assert property (p_width)
      else $error("stored word wider than its table");
endmodule
bind ctp_table_port ctp_table_port_sva u_ctp_table_port_sva (.ref_clk(ref_clk), .rst_b(rst_b),
   .cfg_addr_stb(cfg_addr_stb), .cfg_wr_stb(cfg_wr_stb), .cfg_rd_stb(cfg_rd_stb), .cfg_wdata(cfg_wdata),
   .cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q), .port_busy_q(port_busy_q),
   .select_status_in(select_status_in), .mem_req_q(mem_req_q), .mem_we_q(mem_we_q),
   .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .mem_ack(mem_ack));

/* verif/coefficient_table_port_tb_top.sv */
`timescale 1ns/1ns
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin n_mismatch++; $display("CHECK FAILED at %0t: %s", $time, m); end end
module coefficient_table_port_tb_top;
   logic ref_clk, rst_b, cfg_addr_stb, cfg_wr_stb, cfg_rd_stb, select_status_in, slow;
   logic cfg_rvalid_q, port_busy_q, mem_req_q, mem_we_q, mem_ack;
   logic [7:0] cfg_wdata, cfg_rdata_q;
   logic [19:0] mem_addr_q;
   logic [15:0] mem_wdata_q, mem_rdata;
   int n_mismatch = 0;
   int checked = 0;
   ctp_table_port u_ctp_table_port (.ref_clk(ref_clk), .rst_b(rst_b), .cfg_addr_stb(cfg_addr_stb),
      .cfg_wr_stb(cfg_wr_stb), .cfg_rd_stb(cfg_rd_stb), .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q),
      .cfg_rvalid_q(cfg_rvalid_q), .port_busy_q(port_busy_q), .select_status_in(select_status_in),
      .mem_req_q(mem_req_q), .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   ctp_mem_model u_ctp_mem_model (.ref_clk(ref_clk), .mem_req_q(mem_req_q), .mem_we_q(mem_we_q),
      .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .slow(slow));
   // ==========================================================
   // closing report
   task automatic close_out;
      $display("mismatches %0d comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ==========================================================
   // host strobes: 0 address, 1 write, 2 read; never while the port is busy
   task automatic drive(input int k, input logic [7:0] d);
      int n;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (port_busy_q !== 1'b0 && n < 100);
      if (n >= 100)
      begin
         n_mismatch++;
         close_out();
      end
      cfg_addr_stb <= (k == 0);
      cfg_wr_stb <= (k == 1);
      cfg_rd_stb <= (k == 2);
      cfg_wdata <= d;
      @(posedge ref_clk);
      cfg_addr_stb <= 1'b0;
      cfg_wr_stb <= 1'b0;
      cfg_rd_stb <= 1'b0;
   endtask
   // read the latched address and compare the answer
   task automatic rd_chk(input logic [7:0] e);
      int n;
      n = 0;
      drive(2, 8'h00);
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (cfg_rvalid_q !== 1'b1 && n < 100);
      if (n >= 100)
      begin
         n_mismatch++;
         close_out();
      end
      `CHK(cfg_rdata_q, e, "read answer")
   endtask
   // start index and direction, high register first
   task automatic load(input logic [13:0] idx, input logic dir);
      drive(0, 8'h04);
      drive(1, {1'b0, dir, idx[13:8]});
      drive(0, 8'h05);
      drive(1, idx[7:0]);
      drive(0, 8'h06);
   endtask
   // byte pair of a word as the window carries it
   function automatic logic [15:0] pack(input int t, input logic [15:0] w);
      pack = (t == 0) ? {w[13:6], w[5:0], 2'b00} : w;
   endfunction
   // ==========================================================
   // select register, read-only bit, foreign address
   task automatic t_regs;
      drive(0, 8'h03);
      drive(1, 8'hEF);
      rd_chk(8'h1F);
      drive(0, 8'h04);
      drive(1, 8'hFF);
      rd_chk(8'h7F);
      drive(0, 8'h10);
      drive(2, 8'h00);
      repeat (4)
      begin
         @(posedge ref_clk);
         `CHK(cfg_rvalid_q, 1'b0, "foreign address answered")
      end
   endtask
   // undefined select leaves memory alone and reads zero
   task automatic t_undef;
      load(14'h0000, 1'b0);
      drive(1, 8'hA5);
      drive(1, 8'h5A);
      repeat (8) @(posedge ref_clk);
      `CHK(u_ctp_mem_model.n_wr, 0, "write with undefined select")
      load(14'h0000, 1'b1);
      rd_chk(8'h00);
   endtask
   // every table and colour: two words across the wrap, then read back
   task automatic t_stream;
      logic [13:0] last;
      logic [15:0] w0, w1, b0, b1;
      logic [19:0] at;
      for (int t = 0; t < 3; t++)
      begin
         for (int c = 0; c < 3; c++)
         begin
            last = (t == 2) ? 14'h0FFD : 14'h3FFF;
            w0 = (16'hB6C5 + 16'(t * 3 + c)) & ((t == 0) ? 16'h3FFF : (t == 1) ? 16'hFFFF : 16'h0FFF);
            w1 = ~w0 & ((t == 0) ? 16'h3FFF : (t == 1) ? 16'hFFFF : 16'h0FFF);
            b0 = pack(t, w0);
            b1 = pack(t, w1);
            at = ((t == 0) ? 20'h00000 : (t == 1) ? 20'h0C000 : 20'h18000) + (20'(c) << ((t == 2) ? 12 : 14));
            slow <= (c == 1);
            drive(0, 8'h03);
            drive(1, 8'(c * 4 + t));
            load(last, 1'b0);
            drive(1, b0[15:8]);
            drive(1, b0[7:0]);
            drive(1, b1[15:8]);
            drive(1, b1[7:0]);
            drive(0, 8'h05);
            `CHK(u_ctp_mem_model.mem[at + 20'(last)], w0, "word at last index")
            `CHK(u_ctp_mem_model.mem[at], w1, "word after wrap")
            rd_chk(8'h01);
            load(last, 1'b1);
            rd_chk(b0[15:8]);
            rd_chk(b0[7:0]);
            rd_chk(b1[15:8]);
            rd_chk(b1[7:0]);
         end
      end
   endtask
   // ==========================================================
   // clock, reset and main sequence
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial
   begin
      rst_b = 1'b0;
      cfg_addr_stb = 1'b0;
      cfg_wr_stb = 1'b0;
      cfg_rd_stb = 1'b0;
      cfg_wdata = 8'h00;
      select_status_in = 1'b1;
      slow = 1'b0;
      repeat (20) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_regs();
      t_undef();
      t_stream();
      close_out();
   end
endmodule
